/* File: rtl/tpl_pkg.sv */
// Shared constants for the twisted-pair link control block
`default_nettype none

package tpl_pkg;
	// Core clock period
	localparam int CLK_PERIOD_NS = 10;

	// Squelch qualification and end of packet (longest times: round down)
	localparam int QUAL_NS = 150;
	localparam int QUAL_CYC = QUAL_NS / CLK_PERIOD_NS;
	localparam int EOP_NS = 150;
	localparam int EOP_CYC = EOP_NS / CLK_PERIOD_NS;

	// Bit timing: one bit is 100 ns, the transmit clock is 10 MHz
	localparam int BIT_NS = 100;
	localparam int BIT_CYC = BIT_NS / CLK_PERIOD_NS;
	localparam int HALF_BIT_CYC = BIT_CYC / 2;
	// 20 MHz oscillator tick, divided by two for the transmit clock
	localparam int OSC_TICK_CYC = HALF_BIT_CYC;

	// Collision report delay when the transmitter was first
	localparam int COL_BITS = 7;
	localparam int COL_DELAY_CYC = COL_BITS * BIT_CYC;

	// Heartbeat: about 1 us after transmit end, 10 cycles of 10 MHz
	localparam int SQE_DELAY_NS = 1000;
	localparam int SQE_DELAY_CYC = SQE_DELAY_NS / CLK_PERIOD_NS;
	localparam int SQE_CYCLES = 10;
	localparam int SQE_HALF_NS = 50;
	localparam int SQE_HALF_CYC = SQE_HALF_NS / CLK_PERIOD_NS;
	localparam int SQE_EDGES = 2 * SQE_CYCLES;

	// Link pulse width and transmit pre-emphasis delay
	localparam int LINK_PULSE_NS = 100;
	localparam int LINK_PULSE_CYC = LINK_PULSE_NS / CLK_PERIOD_NS;
	localparam int PREEMPH_NS = 50;
	localparam int PREEMPH_CYC = PREEMPH_NS / CLK_PERIOD_NS;

	// Long timers, in milliseconds
	localparam int NS_PER_MS = 1000000;
	localparam int LINK_PERIOD_MS = 16;
	localparam int LINK_LOSS_MS = 100;
	localparam int JABBER_MS = 26;
	localparam int UNJAB_MS = 750;
	localparam int LINK_PERIOD_CYC = LINK_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int LINK_LOSS_CYC = LINK_LOSS_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int JABBER_CYC = JABBER_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int UNJAB_CYC = UNJAB_MS * (NS_PER_MS / CLK_PERIOD_NS);

	// Synchroniser lane indices
	localparam int SYNC_LANES = 5;
	localparam int LANE_HI_POS = 0;
	localparam int LANE_HI_NEG = 1;
	localparam int LANE_LO_POS = 2;
	localparam int LANE_LO_NEG = 3;
	localparam int LANE_DATA = 4;

	// Squelch qualifier states
	typedef enum logic [1:0] {
		TPL_SQ_IDLE = 2'b00,
		TPL_SQ_OPP = 2'b01,
		TPL_SQ_ORIG = 2'b10,
		TPL_SQ_VALID = 2'b11
	} tpl_sq_e;
endpackage : tpl_pkg

`default_nettype wire

/* File: rtl/tpl_delay_line.sv */
// Fixed-length register delay line for the pre-emphasis copies
`default_nettype none

module tpl_delay_line #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 5
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage [DEPTH];

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stage[0] <= '0;
		end else begin
			stage[0] <= din;
		end
	end

	genvar gi;
	generate
		for (gi = 1; gi < DEPTH; gi++) begin : g_stage
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					stage[gi] <= '0;
				end else begin
					stage[gi] <= stage[gi-1];
				end
			end
		end
	endgenerate

	assign dout = stage[DEPTH-1];
endmodule : tpl_delay_line

`default_nettype wire

/* File: rtl/tpl_link_ctrl.sv */
// Twisted-pair squelch, collision, link, jabber and Manchester control
`default_nettype none

// Summary of operation
// - Qualify: opposite threshold within 150 ns, original again within 150 ns.
// - Start pulses failing the expected threshold are dropped, no reception.
// - Valid data raised only after full sequence; qualifier then resets.
// - End of packet when no crossing is seen for over 150 ns.
// - After good data, lowered thresholds hold for the packet's remainder.
// - Standard or reduced squelch selectable; same sequence, lower levels.
// - Collision when receive and transmit are active together.
// - Receiving first: collision reported at once.
// - Transmitting first: report after seven bit times in collision.
// - Collision indication held for as long as the collision lasts.
// - About 1 us after transmit end, ten 10 MHz heartbeat cycles.
// - Idle transmitter sends a 100 ns positive link pulse every 16 ms.
// - Lost remote link pulses disable transmit, receive and collision.
// - Good-link output active while link good; disable bit turns checking off.
// - Jabber cuts transmit outputs after more than 26 ms active.
// - Stay cut while enable asserted; release after 750 ms deasserted.
// - Drive true and complement Manchester plus 50 ns delayed copies.
// - Transmit clock is the 20 MHz tick divided by two: 10 MHz.
// - Controller NRZ transmit data is encoded to Manchester.
// - Decoder recovers NRZ data and a clock for the controller.
// - Controller is signalled while a valid collision signal is present.
// - Non-standard twisted-pair mode applies lowered receive squelch.
module tpl_link_ctrl #(
	parameter int CNT_W = 27,
	parameter int LINK_PERIOD_CYC = tpl_pkg::LINK_PERIOD_CYC,
	parameter int LINK_LOSS_CYC = tpl_pkg::LINK_LOSS_CYC,
	parameter int JABBER_CYC = tpl_pkg::JABBER_CYC,
	parameter int UNJAB_CYC = tpl_pkg::UNJAB_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Configuration
	input wire logic squelch_reduced,
	input wire logic link_disable,
	// Receive comparators, cable side
	input wire logic rx_diff_in_hi_pos,
	input wire logic rx_diff_in_hi_neg,
	input wire logic rx_diff_in_lo_pos,
	input wire logic rx_diff_in_lo_neg,
	input wire logic rx_diff_in_data,
	// Transmit driver, cable side
	output logic tx_diff_out_pos,
	output logic tx_diff_out_neg,
	output logic tx_delayed_out_pos,
	output logic tx_delayed_out_neg,
	// Controller side
	input wire logic tx_en,
	input wire logic tx_nrz,
	output logic tx_clk_out,
	output logic rx_nrz,
	output logic rx_clk_out,
	output logic carrier_sense,
	output logic collision_out,
	// Status
	output logic good_link_out_n,
	output logic rx_activity_led_n,
	output logic tx_activity_led_n,
	output logic collision_led_n,
	output logic jabber
);
	localparam logic [CNT_W-1:0] LINK_PERIOD_N = CNT_W'(LINK_PERIOD_CYC - 1);
	localparam logic [CNT_W-1:0] LINK_LOSS_N = CNT_W'(LINK_LOSS_CYC);
	localparam logic [CNT_W-1:0] JABBER_N = CNT_W'(JABBER_CYC);
	localparam logic [CNT_W-1:0] UNJAB_N = CNT_W'(UNJAB_CYC);
	localparam logic [4:0] QUAL_N = 5'(tpl_pkg::QUAL_CYC);
	localparam logic [4:0] EOP_N = 5'(tpl_pkg::EOP_CYC);
	localparam logic [3:0] BIT_LAST = 4'(tpl_pkg::BIT_CYC - 1);
	localparam logic [3:0] HALF_BIT = 4'(tpl_pkg::HALF_BIT_CYC);
	localparam logic [3:0] OSC_LAST = 4'(tpl_pkg::OSC_TICK_CYC - 1);
	localparam logic [3:0] RX_MID_MIN = 4'(tpl_pkg::BIT_CYC * 3 / 4);
	localparam logic [7:0] COL_DELAY_N = 8'(tpl_pkg::COL_DELAY_CYC);
	localparam logic [7:0] SQE_DELAY_N = 8'(tpl_pkg::SQE_DELAY_CYC);
	localparam logic [2:0] SQE_HALF_LAST = 3'(tpl_pkg::SQE_HALF_CYC - 1);
	localparam logic [4:0] SQE_EDGES_N = 5'(tpl_pkg::SQE_EDGES);
	localparam logic [3:0] LINK_PULSE_N = 4'(tpl_pkg::LINK_PULSE_CYC);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [tpl_pkg::SYNC_LANES-1:0] rx_raw;
	logic [tpl_pkg::SYNC_LANES-1:0] sync_a;
	logic [tpl_pkg::SYNC_LANES-1:0] rx_s;
	logic [tpl_pkg::SYNC_LANES-1:0] rx_d;

	assign rx_raw = {rx_diff_in_data, rx_diff_in_lo_neg, rx_diff_in_lo_pos,
		rx_diff_in_hi_neg, rx_diff_in_hi_pos};

	genvar gi;
	generate
		for (gi = 0; gi < tpl_pkg::SYNC_LANES; gi++) begin : g_sync
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					sync_a[gi] <= 1'b0;
					rx_s[gi] <= 1'b0;
					rx_d[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= rx_raw[gi];
					rx_s[gi] <= sync_a[gi];
					rx_d[gi] <= rx_s[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Smart squelch
	tpl_pkg::tpl_sq_e sq_state;
	tpl_pkg::tpl_sq_e next_sq_state;
	logic first_pos;
	logic [4:0] sq_timer;
	logic link_good;
	logic rx_valid;

	// Reduced mode only swaps which comparator pair qualifies
	wire qual_pos = squelch_reduced ? rx_s[tpl_pkg::LANE_LO_POS] : rx_s[tpl_pkg::LANE_HI_POS];
	wire qual_neg = squelch_reduced ? rx_s[tpl_pkg::LANE_LO_NEG] : rx_s[tpl_pkg::LANE_HI_NEG];
	wire lo_any = rx_s[tpl_pkg::LANE_LO_POS] | rx_s[tpl_pkg::LANE_LO_NEG];
	wire opp_seen = first_pos ? qual_neg : qual_pos;
	wire orig_seen = first_pos ? qual_pos : qual_neg;
	// Last allowed step lands at timer QUAL_N-1; one more cycle is too late
	wire sq_expired = (sq_timer >= QUAL_N - 5'h01);
	wire eop_expired = (sq_timer > EOP_N);

	always_comb begin
		next_sq_state = sq_state;
		case (sq_state)
			tpl_pkg::TPL_SQ_IDLE: begin
				if (qual_pos | qual_neg) begin
					next_sq_state = tpl_pkg::TPL_SQ_OPP;
				end
			end
			tpl_pkg::TPL_SQ_OPP: begin
				if (opp_seen) begin
					next_sq_state = tpl_pkg::TPL_SQ_ORIG;
				end else if (sq_expired) begin
					next_sq_state = tpl_pkg::TPL_SQ_IDLE;
				end
			end
			tpl_pkg::TPL_SQ_ORIG: begin
				if (orig_seen) begin
					next_sq_state = tpl_pkg::TPL_SQ_VALID;
				end else if (sq_expired) begin
					next_sq_state = tpl_pkg::TPL_SQ_IDLE;
				end
			end
			tpl_pkg::TPL_SQ_VALID: begin
				if (eop_expired) begin
					next_sq_state = tpl_pkg::TPL_SQ_IDLE;
				end
			end
			default: next_sq_state = tpl_pkg::TPL_SQ_IDLE;
		endcase
	end

	// Qualifying timer restarts per step; in data it measures silence
	wire sq_step = (next_sq_state != sq_state);
	wire data_edge = (sq_state == tpl_pkg::TPL_SQ_VALID) & lo_any;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sq_state <= tpl_pkg::TPL_SQ_IDLE;
			first_pos <= 1'b0;
			sq_timer <= '0;
		end else begin
			sq_state <= next_sq_state;
			if (sq_state == tpl_pkg::TPL_SQ_IDLE) begin
				first_pos <= qual_pos;
			end
			if (sq_step | data_edge) begin
				sq_timer <= '0;
			end else if (sq_timer != '1) begin
				sq_timer <= sq_timer + 5'h01;
			end
		end
	end

	// Data indication only after the whole sequence, gated by link
	assign rx_valid = (sq_state == tpl_pkg::TPL_SQ_VALID) & link_good;

	////////////////////////////////////////////////////////////////////////
	// Link integrity
	logic [CNT_W-1:0] loss_cnt;
	logic link_fail;
	// A lone positive crossing that never qualifies is a remote link pulse
	wire link_pulse_rx = (sq_state == tpl_pkg::TPL_SQ_OPP) & sq_expired & first_pos;
	wire link_seen = link_pulse_rx | (sq_state == tpl_pkg::TPL_SQ_VALID);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			loss_cnt <= '0;
			link_fail <= 1'b0;
		end else if (link_disable) begin
			loss_cnt <= '0;
			link_fail <= 1'b0;
		end else if (link_seen) begin
			loss_cnt <= '0;
			link_fail <= 1'b0;
		end else if (loss_cnt >= LINK_LOSS_N) begin
			link_fail <= 1'b1;
		end else begin
			loss_cnt <= loss_cnt + 1'b1;
		end
	end

	assign link_good = ~link_fail;

	////////////////////////////////////////////////////////////////////////
	// Jabber
	logic [CNT_W-1:0] jab_cnt;
	logic jabbed;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			jab_cnt <= '0;
			jabbed <= 1'b0;
		end else if (!jabbed) begin
			if (!tx_en) begin
				jab_cnt <= '0;
			end else if (jab_cnt > JABBER_N) begin
				jabbed <= 1'b1;
				jab_cnt <= '0;
			end else begin
				jab_cnt <= jab_cnt + 1'b1;
			end
		end else if (tx_en) begin
			jab_cnt <= '0;
		end else if (jab_cnt >= UNJAB_N) begin
			jabbed <= 1'b0;
			jab_cnt <= '0;
		end else begin
			jab_cnt <= jab_cnt + 1'b1;
		end
	end

	wire tx_active = tx_en & ~jabbed & link_good;

	////////////////////////////////////////////////////////////////////////
	// Transmit clock, encoder and link pulses
	logic [3:0] osc_cnt;
	logic osc_phase;
	logic [3:0] bit_cnt;
	logic tx_bit;
	logic [CNT_W-1:0] lp_cnt;
	logic [3:0] lp_width;
	logic tx_p;
	logic tx_n;

	wire osc_tick = (osc_cnt == OSC_LAST);
	wire bit_start = (bit_cnt == BIT_LAST);
	// Second half carries the bit, first half its complement
	wire manch = (bit_cnt < HALF_BIT) ? ~tx_bit : tx_bit;
	wire lp_due = (lp_cnt == LINK_PERIOD_N);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			osc_cnt <= '0;
			osc_phase <= 1'b0;
			bit_cnt <= '0;
			tx_clk_out <= 1'b0;
		end else begin
			osc_cnt <= osc_tick ? 4'h0 : osc_cnt + 4'h1;
			if (osc_tick) begin
				osc_phase <= ~osc_phase;
			end
			bit_cnt <= bit_start ? 4'h0 : bit_cnt + 4'h1;
			tx_clk_out <= ~osc_phase;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_bit <= 1'b0;
			lp_cnt <= '0;
			lp_width <= '0;
			tx_p <= 1'b0;
			tx_n <= 1'b0;
		end else begin
			if (bit_start) begin
				tx_bit <= tx_nrz;
			end
			// No link pulse while cut off, and no partial one after release
			if (tx_en | jabbed) begin
				lp_cnt <= '0;
				lp_width <= '0;
			end else if (lp_due) begin
				lp_cnt <= '0;
				lp_width <= LINK_PULSE_N;
			end else begin
				lp_cnt <= lp_cnt + 1'b1;
				if (lp_width != '0) begin
					lp_width <= lp_width - 4'h1;
				end
			end
			// Idle leaves both legs low outside link pulses, which drive only the positive leg
			tx_p <= tx_active ? manch : (~tx_en & (lp_width != '0));
			tx_n <= tx_active & ~manch;
		end
	end

	assign tx_diff_out_pos = tx_p;
	assign tx_diff_out_neg = tx_n;

	tpl_delay_line #(
		.WIDTH(2),
		.DEPTH(tpl_pkg::PREEMPH_CYC)
	) u_preemph (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.din({tx_n, tx_p}),
		.dout({tx_delayed_out_neg, tx_delayed_out_pos})
	);

	////////////////////////////////////////////////////////////////////////
	// Manchester decoder
	logic [3:0] rx_gap;
	logic [2:0] rx_clk_hold;
	wire rx_edge = rx_s[tpl_pkg::LANE_DATA] ^ rx_d[tpl_pkg::LANE_DATA];
	// Only edges at least three quarters of a bit apart are mid-bit
	wire rx_mid = rx_valid & rx_edge & (rx_gap >= RX_MID_MIN);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_gap <= '0;
			rx_clk_hold <= '0;
			rx_nrz <= 1'b0;
			rx_clk_out <= 1'b0;
			carrier_sense <= 1'b0;
		end else begin
			if (rx_mid | ~rx_valid) begin
				rx_gap <= '0;
			end else if (rx_gap != '1) begin
				rx_gap <= rx_gap + 4'h1;
			end
			if (rx_mid) begin
				rx_nrz <= rx_s[tpl_pkg::LANE_DATA];
				rx_clk_hold <= 3'(tpl_pkg::HALF_BIT_CYC - 1);
			end else if (rx_clk_hold != '0) begin
				rx_clk_hold <= rx_clk_hold - 3'h1;
			end
			rx_clk_out <= rx_mid | (rx_clk_hold != '0);
			carrier_sense <= rx_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Collision and heartbeat
	logic tx_active_d;
	logic col_prev;
	logic rx_first;
	logic [7:0] col_cnt;
	logic [7:0] sqe_wait;
	logic [4:0] sqe_edges;
	logic [2:0] sqe_half;
	logic sqe_wave;

	wire col_cond = rx_valid & tx_active;
	// First collision cycle must not reuse the order of the previous collision
	wire rx_first_now = (col_cond & ~col_prev) ? ~tx_active_d : rx_first;
	wire col_report = col_cond & (rx_first_now | (col_cnt >= COL_DELAY_N));
	wire tx_end = tx_active_d & ~tx_active;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_active_d <= 1'b0;
			col_prev <= 1'b0;
			rx_first <= 1'b0;
			col_cnt <= '0;
		end else begin
			tx_active_d <= tx_active;
			col_prev <= col_cond;
			if (col_cond & ~col_prev) begin
				rx_first <= ~tx_active_d;
			end
			if (!col_cond) begin
				col_cnt <= '0;
			end else if (col_cnt < COL_DELAY_N) begin
				col_cnt <= col_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sqe_wait <= '0;
			sqe_edges <= '0;
			sqe_half <= '0;
			sqe_wave <= 1'b0;
		end else if (tx_end) begin
			sqe_wait <= SQE_DELAY_N;
			sqe_edges <= '0;
			sqe_wave <= 1'b0;
		end else if (sqe_wait != '0) begin
			sqe_wait <= sqe_wait - 8'h01;
			if (sqe_wait == 8'h01) begin
				sqe_edges <= SQE_EDGES_N;
				sqe_half <= SQE_HALF_LAST;
				sqe_wave <= 1'b1;
			end
		end else if (sqe_edges != '0) begin
			if (sqe_half == '0) begin
				sqe_half <= SQE_HALF_LAST;
				sqe_edges <= sqe_edges - 5'h01;
				sqe_wave <= (sqe_edges != 5'h01) & ~sqe_wave;
			end else begin
				sqe_half <= sqe_half - 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			collision_out <= 1'b0;
			good_link_out_n <= 1'b0;
			rx_activity_led_n <= 1'b1;
			tx_activity_led_n <= 1'b1;
			collision_led_n <= 1'b1;
			jabber <= 1'b0;
		end else begin
			collision_out <= col_report | sqe_wave;
			good_link_out_n <= ~link_good;
			rx_activity_led_n <= ~rx_valid;
			tx_activity_led_n <= ~tx_active;
			collision_led_n <= ~col_report;
			jabber <= jabbed;
		end
	end
endmodule : tpl_link_ctrl

`default_nettype wire

/* File: test/tpl_link_ctrl_props.sv */
// Port-level assertions for the twisted-pair link control block
`default_nettype none

module tpl_link_ctrl_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Watched inputs
	input wire logic link_disable,
	input wire logic tx_en,
	input wire logic rx_diff_in_lo_pos,
	input wire logic rx_diff_in_lo_neg,
	// Watched outputs
	input wire logic tx_diff_out_pos,
	input wire logic tx_diff_out_neg,
	input wire logic tx_delayed_out_pos,
	input wire logic tx_delayed_out_neg,
	input wire logic tx_clk_out,
	input wire logic carrier_sense,
	input wire logic collision_out,
	input wire logic good_link_out_n,
	input wire logic jabber
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////
	// Idle age gates the link pulse check; reset age keeps $past clear of reset
	logic [4:0] idle_cnt;
	logic [2:0] age;
	always_ff @(posedge core_clk) begin
		if (sys_rst || tx_en) begin
			idle_cnt <= 5'h00;
		end else if (idle_cnt != 5'h1F) begin
			idle_cnt <= idle_cnt + 5'h01;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			age <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end

	////////////////////////////////
	sequence s_hi5;
		tx_clk_out [*5];
	endsequence
	sequence s_lo5;
		!tx_clk_out [*5];
	endsequence
	sequence s_pulse5;
		(tx_diff_out_pos && !tx_diff_out_neg) [*5];
	endsequence
	sequence s_quiet;
		(!rx_diff_in_lo_pos && !rx_diff_in_lo_neg) [*8] ##1
		(!rx_diff_in_lo_pos && !rx_diff_in_lo_neg) [*8];
	endsequence

	property p_jab_cut;
		jabber && $past(jabber, 2) |-> !tx_diff_out_pos && !tx_diff_out_neg;
	endproperty
	a_jab_cut: assert property (p_jab_cut) else $error("drive while cut off");
	property p_pre_emph;
		age == 3'h7 |-> {tx_delayed_out_pos, tx_delayed_out_neg} ==
			$past({tx_diff_out_pos, tx_diff_out_neg}, 5);
	endproperty
	a_pre_emph: assert property (p_pre_emph) else $error("delayed copy wrong");
	property p_tx_clk;
		$rose(tx_clk_out) |-> s_hi5 ##1 s_lo5 ##1 tx_clk_out;
	endproperty
	a_tx_clk: assert property (p_tx_clk) else $error("transmit clock shape");
	property p_link_pulse;
		$rose(tx_diff_out_pos) && idle_cnt == 5'h1F |-> s_pulse5 ##1 s_pulse5 ##1
			!tx_diff_out_pos;
	endproperty
	a_link_pulse: assert property (p_link_pulse) else $error("link pulse width");
	property p_col_rx;
		$rose(tx_en) && carrier_sense && !good_link_out_n && !jabber |->
			##[1:6] collision_out;
	endproperty
	a_col_rx: assert property (p_col_rx) else $error("late collision report");
	property p_col_hold;
		collision_out && tx_en && carrier_sense ##1 tx_en && carrier_sense |-> collision_out;
	endproperty
	a_col_hold: assert property (p_col_hold) else $error("collision dropped");
	property p_rx_eop;
		s_quiet |-> ##[1:10] !carrier_sense;
	endproperty
	a_rx_eop: assert property (p_rx_eop) else $error("end of packet missed");
	property p_link_dis;
		link_disable && $past(link_disable, 3) |-> !good_link_out_n;
	endproperty
	a_link_dis: assert property (p_link_dis) else $error("link bad while off");
	property p_link_dead;
		good_link_out_n && $past(good_link_out_n, 3) |-> !carrier_sense && !tx_diff_out_neg;
	endproperty
	a_link_dead: assert property (p_link_dead) else $error("active on dead link");
endmodule : tpl_link_ctrl_props

`default_nettype wire

/* File: test/tpl_remote_model.sv */
// Remote transceiver as seen through the receive comparators
`default_nettype none

module tpl_remote_model (
	// Clock
	input wire logic core_clk,
	// Comparator outputs toward the block
	output logic hi_pos,
	output logic hi_neg,
	output logic lo_pos,
	output logic lo_neg,
	output logic rx_data
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		{hi_pos, hi_neg, lo_pos, lo_neg, rx_data} = 5'h00;
	end

	////////////////////////////////
	// Weak swings cross only the low threshold
	task automatic drive(input logic p, input logic n, input logic w, input int c);
		hi_pos = p & ~w;
		hi_neg = n & ~w;
		lo_pos = p;
		lo_neg = n;
		// Quiet line shows the inverse of its last level, never a held value
		rx_data = (p | n) ? p : ~rx_data;
		repeat (c) @(negedge core_clk);
	endtask : drive

	// Start crossings with adjustable gaps, callers sit at a falling edge
	task automatic start(input int g1, input int g2);
		drive(1'b1, 1'b0, 1'b0, 5);
		if (g1 > 0) begin
			drive(1'b0, 1'b0, 1'b0, g1);
		end
		drive(1'b0, 1'b1, 1'b0, 5);
		if (g2 > 0) begin
			drive(1'b0, 1'b0, 1'b0, g2);
		end
		drive(1'b1, 1'b0, 1'b0, 5);
		drive(1'b0, 1'b0, 1'b0, 40);
	endtask : start

	// Manchester frame, first half inverted; weak from bit wf on
	task automatic frame(input logic [23:0] b, input int wf);
		for (int i = 23; i >= 0; i--) begin
			drive(~b[i], b[i], (23 - i) >= wf, 5);
			drive(b[i], ~b[i], (23 - i) >= wf, 5);
		end
		drive(1'b0, 1'b0, 1'b0, 40);
	endtask : frame
endmodule : tpl_remote_model

`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the twisted-pair link control block
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// Short timers keep the run small
	localparam int LPC = 200;
	localparam int LLC = 1000;
	localparam int JC = 500;
	localparam int UC = 300;
	localparam int P = 0, CS = 1, CO = 2, JB = 3, LK = 4, TC = 5;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic squelch_reduced = 1'b0;
	logic link_disable = 1'b1;
	logic tx_en = 1'b0;
	logic tx_nrz = 1'b0;
	logic hp, hn, lp, ln, rd, prc, pco;
	logic tx_diff_out_pos, tx_diff_out_neg, tx_delayed_out_pos, tx_delayed_out_neg;
	logic tx_clk_out, rx_nrz, rx_clk_out, carrier_sense, collision_out;
	logic good_link_out_n, rx_activity_led_n, tx_activity_led_n, collision_led_n, jabber;
	logic [7:0] rsh;
	logic [5:0] mon;
	int error_cnt = 0;
	int check_count = 0;
	int ccnt = 0;
	int crise = 0;
	assign mon = {tx_clk_out, good_link_out_n, jabber, collision_out, carrier_sense,
		tx_diff_out_pos};

	tpl_link_ctrl #(.LINK_PERIOD_CYC(LPC), .LINK_LOSS_CYC(LLC), .JABBER_CYC(JC),
		.UNJAB_CYC(UC)) dut_u (.core_clk, .sys_rst, .squelch_reduced, .link_disable,
		.rx_diff_in_hi_pos(hp), .rx_diff_in_hi_neg(hn), .rx_diff_in_lo_pos(lp),
		.rx_diff_in_lo_neg(ln), .rx_diff_in_data(rd), .tx_diff_out_pos, .tx_diff_out_neg,
		.tx_delayed_out_pos, .tx_delayed_out_neg, .tx_en, .tx_nrz, .tx_clk_out, .rx_nrz,
		.rx_clk_out, .carrier_sense, .collision_out, .good_link_out_n, .rx_activity_led_n,
		.tx_activity_led_n, .collision_led_n, .jabber);
	tpl_remote_model rm (.core_clk, .hi_pos(hp), .hi_neg(hn), .lo_pos(lp), .lo_neg(ln),
		.rx_data(rd));

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	// Carrier cycles, collision rises and decoded bits
	always @(negedge core_clk) begin
		if (carrier_sense === 1'b1) ccnt <= ccnt + 1;
		if (collision_out === 1'b1 && pco !== 1'b1) crise <= crise + 1;
		if (rx_clk_out === 1'b1 && prc !== 1'b1) rsh <= {rsh[6:0], rx_nrz};
		prc <= rx_clk_out;
		pco <= collision_out;
	end

	////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %0h seen %0h", s, e, g);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task automatic wt(input int s, input logic v, input int lim, output int n);
		for (n = 0; n < lim && mon[s] !== v; n++) begin
			@(negedge core_clk);
		end
		if (n == lim) begin
			error_cnt++;
			$display("BAD wait%0d expected %0h seen timeout", s, v);
			stop_test();
		end
	endtask : wt
	// Raise the enable only between link pulses, never cutting one short
	task automatic quiet();
		int k;
		wt(P, 1'b1, LPC + 20, k);
		wt(P, 1'b0, 20, k);
	endtask : quiet
	function automatic logic [1:0] mexp(input logic b, input logic h);
		return h ? {b, ~b} : {~b, b};
	endfunction : mexp
	function automatic logic [31:0] inr(input int v, input int lo, input int hi);
		return {31'h0, (v >= lo) && (v <= hi)};
	endfunction : inr
	// Random NRZ bits, one per transmit clock rise
	task automatic tx_frame(input int nb);
		logic [31:0] b;
		int k;
		b = $urandom();
		quiet();
		for (int i = 0; i <= nb; i++) begin
			wt(TC, 1'b0, 12, k);
			wt(TC, 1'b1, 12, k);
			tx_nrz = b[i % 32];
			if (i > 0) begin
				cyc(2);
				chk("tx_half1", mexp(b[i - 1], 0), {tx_diff_out_pos, tx_diff_out_neg});
				cyc(5);
				chk("tx_half2", mexp(b[i - 1], 1), {tx_diff_out_pos, tx_diff_out_neg});
			end
			// Enable drops only after the last bit has been seen
			tx_en = (i < nb);
		end
	endtask : tx_frame

	////////////////////////////////
	initial begin
		int n, k, c0;
		logic [7:0] d;
		int g1 [4] = '{0, 4, 11, 0};
		int g2 [4] = '{0, 4, 0, 11};
		int sm [4] = '{0, 1, 0, 0};
		int wf [4] = '{24, 0, 16, 0};
		n = $urandom(32'hAC3E68EA);
		cyc(12);
		sys_rst = 1'b0;
		cyc(1);
		chk("reset", 9'h007, {tx_diff_out_pos, tx_diff_out_neg, carrier_sense, collision_out,
			good_link_out_n, jabber, rx_activity_led_n, tx_activity_led_n,
			collision_led_n});
		for (int i = 0; i < 4; i++) begin
			c0 = ccnt;
			rm.start(g1[i], g2[i]);
			chk("qualify", i < 2, ccnt != c0);
		end
		$display("test squelch finished");
		for (int i = 0; i < 4; i++) begin
			squelch_reduced = sm[i][0];
			d = 8'($urandom());
			c0 = ccnt;
			rm.frame({16'h5555, d}, wf[i]);
			chk("carrier", i < 3, ccnt != c0);
			if (i < 3) begin
				chk("rx_data", d, rsh);
			end
		end
		squelch_reduced = 1'b0;
		$display("test receive finished");
		c0 = crise;
		tx_frame(16);
		wt(CO, 1'b1, 200, n);
		chk("sqe_delay", 1, inr(n, 95, 115));
		cyc(250);
		chk("sqe_count", 10, crise - c0);
		$display("test transmit finished");
		wt(P, 1'b1, LPC + 20, n);
		wt(P, 1'b0, 20, n);
		chk("pulse_width", 10, n);
		wt(P, 1'b1, LPC, k);
		chk("pulse_period", LPC, n + k);
		$display("test link pulse finished");
		wt(P, 1'b0, 20, n);
		tx_en = 1'b1;
		wt(JB, 1'b1, JC + 50, n);
		chk("jab_time", 1, inr(n, JC - 5, JC + 10));
		cyc(UC + 50);
		chk("jab_hold", 1, jabber);
		tx_en = 1'b0;
		wt(JB, 1'b0, UC + 50, n);
		chk("unjab_time", 1, inr(n, UC - 5, UC + 10));
		cyc(300);
		$display("test jabber finished");
		for (int i = 0; i < 2; i++) begin
			quiet();
			tx_en = (i == 1);
			cyc(20);
			fork
				rm.frame({16'h5555, 8'($urandom())}, 24);
			join_none
			wt(CS, 1'b1, 60, n);
			tx_en = 1'b1;
			wt(CO, 1'b1, 100, n);
			chk("col_delay", 1, i ? inr(n, 64, 76) : inr(n, 1, 6));
			cyc(20);
			chk("col_hold", 1, collision_out);
			chk("leds", 0, {rx_activity_led_n, tx_activity_led_n, collision_led_n});
			wait fork;
			tx_en = 1'b0;
			cyc(300);
		end
		$display("test collision finished");
		link_disable = 1'b0;
		wt(LK, 1'b1, LLC + 100, n);
		quiet();
		tx_en = 1'b1;
		cyc(30);
		chk("dead_tx", 0, {tx_diff_out_pos, tx_diff_out_neg});
		c0 = ccnt;
		// A qualified packet counts as link activity and revives the link
		rm.frame({16'h5555, 8'h3C}, 24);
		chk("relink_rx", 1, ccnt != c0);
		tx_en = 1'b0;
		link_disable = 1'b1;
		cyc(4);
		chk("link_off", 0, good_link_out_n);
		$display("test link finished");
		stop_test();
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		error_cnt++;
		$display("BAD run expected end seen timeout");
		stop_test();
	end
endmodule : tb_top

bind tpl_link_ctrl tpl_link_ctrl_props u_props (.core_clk, .sys_rst, .link_disable, .tx_en,
	.rx_diff_in_lo_pos, .rx_diff_in_lo_neg, .tx_diff_out_pos, .tx_diff_out_neg,
	.tx_delayed_out_pos, .tx_delayed_out_neg, .tx_clk_out, .carrier_sense, .collision_out,
	.good_link_out_n, .jabber);

`default_nettype wire
